// ### design/fcsl_pkg.sv
// Shared constants, types and register map of the flash command controller
package fcsl_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // Control and status field positions
  localparam int CTRL_NOWAIT_BIT  = 4;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_ERROR_BIT   = 1;
  localparam int STAT_SUSP_BIT    = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam int STAT_DONE_BIT    = 4;
  // Status word bits of the flash
  localparam int DQ_POLL   = 7;
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_ERROR  = 5;
  // Command codes and unlock addresses
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2AA;
  localparam logic [7:0]  CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0]  CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CODE_RESET   = 8'hF0;
  localparam logic [7:0]  CODE_IDENT   = 8'h90;
  localparam logic [7:0]  CODE_PROGRAM = 8'hA0;
  localparam logic [7:0]  CODE_BYPASS  = 8'h20;
  localparam logic [7:0]  CODE_EXIT2   = 8'h00;
  localparam logic [7:0]  CODE_ERASE   = 8'h80;
  localparam logic [7:0]  CODE_CHIP    = 8'h10;
  localparam logic [7:0]  CODE_BLOCK   = 8'h30;
  localparam logic [7:0]  CODE_SUSPEND = 8'hB0;
  localparam logic [7:0]  CODE_RESUME  = 8'h30;
  // Pin timing at 100 MHz
  localparam int CLK_NS        = 10;
  localparam int WE_LOW_NS     = 50;
  localparam int WE_HIGH_NS    = 30;
  localparam int RD_ACCESS_NS  = 70;
  localparam int RD_GAP_NS     = 20;
  localparam int SYNC_STAGES   = 2;
  localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC   = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_WAIT_CYC   = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int RD_GAP_CYC    = (RD_GAP_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET1 = 4'h1, OP_RESET3 = 4'h2, OP_IDENT = 4'h3,
    OP_PROGRAM = 4'h4, OP_BYP_ENTER = 4'h5, OP_BYP_PROG = 4'h6, OP_BYP_EXIT = 4'h7,
    OP_CHIP_ERASE = 4'h8, OP_BLOCK_ERASE = 4'h9, OP_BLOCK_ADD = 4'hA,
    OP_SUSPEND = 4'hB, OP_RESUME = 4'hC, OP_POLL = 4'hD
  } fcsl_op_type;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_WR_LOW = 5'h02, S_WR_HIGH = 5'h04, S_RD_WAIT = 5'h08, S_RD_GAP = 5'h10
  } fcsl_state_type;

  // Flash pin bundle driven by the controller
  typedef struct packed {
    logic        ceN;
    logic        oeN;
    logic        weN;
    logic        dqOe;
    logic [15:0] addr;
    logic [15:0] dqOut;
  } fcsl_pins_type;
endpackage : fcsl_pkg

// ### design/fcsl_flash_ctrl.sv
// Host controller that issues flash command sequences and polls the status word
// Contract
// - Resume is one write 0x30, repeatable
// - Reset is F0, or unlock plus F0
// - Identify is unlock pair then 0x90
// - Program is unlock, A0, then address/data
// - Bypass entry 0x20; bypass program A0,data
// - Bypass exit writes 0x90 then 0x00
// - Erase prefix five writes; chip/block finish
// - Suspend is one write 0xB0
// - After error host issues reset first
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fcsl_flash_ctrl (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  output fcsl_pkg::fcsl_pins_type    flashPins,
  input  wire logic [15:0]           dqIn
);
  import fcsl_pkg::*;

  fcsl_state_type stateReg, stateNext;
  fcsl_op_type    opReg;
  fcsl_pins_type  pinsNext;
  logic [2:0]  stepReg, stepNext;
  logic [3:0]  cntReg;
  logic [15:0] addrReg, wdataReg, rdataReg, prevReg;
  logic [15:0] dqMeta, dqSync;
  logic        noWaitReg, hasPrevReg, errCheckReg;
  logic        errorReg, suspReg, refusedReg, doneReg;
  logic        apbWr, ctrlWr, accept, opDone, opFail, sampleNow, mapped;
  fcsl_op_type opIn;

  // Number of bus writes each operation issues
  function automatic logic [2:0] wrCount(input fcsl_op_type op);
    unique case (op)
      OP_READ, OP_POLL:                               wrCount = 3'd0;
      OP_RESET1, OP_BLOCK_ADD, OP_SUSPEND, OP_RESUME: wrCount = 3'd1;
      OP_BYP_PROG, OP_BYP_EXIT:                       wrCount = 3'd2;
      OP_RESET3, OP_IDENT, OP_BYP_ENTER:              wrCount = 3'd3;
      OP_PROGRAM:                                     wrCount = 3'd4;
      default:                                        wrCount = 3'd6;
    endcase
  endfunction : wrCount

  // Polling operations wait for the embedded controller to settle
  function automatic logic pollsAfter(input fcsl_op_type op);
    pollsAfter = op inside {OP_PROGRAM, OP_BYP_PROG, OP_CHIP_ERASE, OP_BLOCK_ERASE,
                            OP_SUSPEND, OP_RESUME, OP_POLL};
  endfunction : pollsAfter

  // Address and data of write step; command writes other than the 0x30 block write leave upper bits zero as the flash ignores them
  function automatic logic [31:0] seqWord(input fcsl_op_type op, input logic [2:0] step,
                                          input logic [15:0] a, input logic [15:0] d);
    logic [10:0] ua;
    logic [7:0]  ud;
    ua = 11'h000;
    ud = 8'h00;
    seqWord = 32'h0000_0000;
    if (op inside {OP_RESET1, OP_BYP_PROG, OP_BYP_EXIT, OP_BLOCK_ADD, OP_SUSPEND, OP_RESUME})
      unique case (op)
        OP_RESET1:   ud = CODE_RESET;
        OP_BYP_PROG: if (step == 3'd0) ud = CODE_PROGRAM; else seqWord = {a, d};
        OP_BYP_EXIT: ud = (step == 3'd0) ? CODE_IDENT : CODE_EXIT2;
        OP_BLOCK_ADD: seqWord = {a, 8'h00, CODE_BLOCK};
        OP_SUSPEND:  ud = CODE_SUSPEND;
        default:     ud = CODE_RESUME;
      endcase
    else
      unique case (step)
        3'd0, 3'd3: begin ua = UNLOCK_ADDR1; ud = CODE_UNLOCK1; end
        3'd1, 3'd4: begin ua = UNLOCK_ADDR2; ud = CODE_UNLOCK2; end
        3'd2: begin
          ua = (op == OP_RESET3) ? 11'h000 : UNLOCK_ADDR1;
          unique case (op)
            OP_RESET3:    ud = CODE_RESET;
            OP_IDENT:     ud = CODE_IDENT;
            OP_PROGRAM:   ud = CODE_PROGRAM;
            OP_BYP_ENTER: ud = CODE_BYPASS;
            default:      ud = CODE_ERASE;
          endcase
        end
        default: begin
          ua = UNLOCK_ADDR1;
          ud = CODE_CHIP;
        end
      endcase
    if (op == OP_PROGRAM && step == 3'd3) seqWord = {a, d};
    else if (op == OP_BLOCK_ERASE && step == 3'd5) seqWord = {a, 8'h00, CODE_BLOCK};
    else if (seqWord == 32'h0000_0000) seqWord = {5'h00, ua, 8'h00, ud};
  endfunction : seqWord

  // APB decode; the slave always answers in the first access cycle
  assign pready = 1'b1;
  assign apbWr  = psel && penable && pwrite;
  assign mapped = paddr inside {REG_CTRL, REG_ADDR, REG_WDATA, REG_STATUS, REG_RDATA};
  assign pslverr = psel && penable && !mapped;
  assign ctrlWr = apbWr && paddr == REG_CTRL;
  assign opIn   = fcsl_op_type'(pwdata[3:0]);
  // After an error only a reset is passed to the flash
  // Codes above the poll op would fall into an erase sequence, so they are refused
  assign accept = ctrlWr && stateReg == S_IDLE && pwdata[3:0] <= OP_POLL &&
                  (!errorReg || opIn inside {OP_RESET1, OP_RESET3});

  always_comb begin
    unique case (paddr)
      REG_CTRL:   prdata = {27'h0, noWaitReg, opReg};
      REG_ADDR:   prdata = {16'h0, addrReg};
      REG_WDATA:  prdata = {16'h0, wdataReg};
      REG_STATUS: prdata = {27'h0, doneReg, refusedReg, suspReg, errorReg,
                            stateReg != S_IDLE};
      REG_RDATA:  prdata = {16'h0, rdataReg};
      default:    prdata = 32'h0000_0000;
    endcase
  end

  // Software-written operands
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addrReg   <= 16'h0000;
      wdataReg  <= 16'h0000;
      opReg     <= OP_READ;
      noWaitReg <= 1'b0;
    end else begin
      if (apbWr && paddr == REG_ADDR) addrReg <= pwdata[15:0];
      if (apbWr && paddr == REG_WDATA) wdataReg <= pwdata[15:0];
      if (accept) begin
        opReg     <= opIn;
        noWaitReg <= pwdata[CTRL_NOWAIT_BIT];
      end
    end
  end

  // Data bus synchroniser, flash outputs are asynchronous to the clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dqMeta <= 16'h0000;
      dqSync <= 16'h0000;
    end else begin
      dqMeta <= dqIn;
      dqSync <= dqMeta;
    end
  end

  // Sequencer: writes, then reads until the toggle bit settles
  always_comb begin
    stateNext = stateReg;
    stepNext  = stepReg;
    opDone    = 1'b0;
    opFail    = 1'b0;
    sampleNow = stateReg == S_RD_WAIT && cntReg == 4'd0;
    unique case (stateReg)
      S_IDLE: if (accept) begin
        stepNext  = 3'd0;
        stateNext = (wrCount(opIn) != 3'd0) ? S_WR_LOW : S_RD_WAIT;
      end
      S_WR_LOW: if (cntReg == 4'd0) stateNext = S_WR_HIGH;
      S_WR_HIGH: if (cntReg == 4'd0) begin
        if (stepReg + 3'd1 < wrCount(opReg)) begin
          stepNext  = stepReg + 3'd1;
          stateNext = S_WR_LOW;
        end else if (pollsAfter(opReg) && !noWaitReg) stateNext = S_RD_WAIT;
        else begin
          stateNext = S_IDLE;
          opDone    = 1'b1;
        end
      end
      S_RD_WAIT: if (cntReg == 4'd0) stateNext = S_RD_GAP;
      S_RD_GAP: if (cntReg == 4'd0) begin
        // Two equal toggle bits mean the flash is back in read mode or halted
        if (opReg == OP_READ ||
            (hasPrevReg && prevReg[DQ_TOGGLE] == rdataReg[DQ_TOGGLE])) begin
          stateNext = S_IDLE;
          opDone    = 1'b1;
        end else if (hasPrevReg && errCheckReg) begin
          stateNext = S_IDLE;
          opFail    = 1'b1;
        end else stateNext = S_RD_WAIT;
      end
      default: stateNext = S_IDLE;
    endcase
  end

  // Pin levels registered so strobes are glitch free
  always_comb begin
    pinsNext       = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, dqOe: 1'b0,
                       addr: addrReg, dqOut: 16'h0000};
    pinsNext.ceN   = stateNext == S_IDLE;
    pinsNext.oeN   = stateNext != S_RD_WAIT;
    pinsNext.weN   = stateNext != S_WR_LOW;
    pinsNext.dqOe  = stateNext inside {S_WR_LOW, S_WR_HIGH};
    if (pinsNext.dqOe) {pinsNext.addr, pinsNext.dqOut} =
      seqWord(stateReg == S_IDLE ? opIn : opReg, stepNext, addrReg, wdataReg);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stateReg  <= S_IDLE;
      stepReg   <= 3'd0;
      flashPins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, dqOe: 1'b0,
                     addr: 16'h0000, dqOut: 16'h0000};
    end else begin
      stateReg  <= stateNext;
      stepReg   <= stepNext;
      flashPins <= pinsNext;
    end
  end

  // Phase timer, reloaded on every state change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cntReg <= 4'd0;
    else if (stateNext != stateReg)
      unique case (stateNext)
        S_WR_LOW:  cntReg <= 4'(WE_LOW_CYC - 1);
        S_WR_HIGH: cntReg <= 4'(WE_HIGH_CYC - 1);
        S_RD_WAIT: cntReg <= 4'(RD_WAIT_CYC - 1);
        S_RD_GAP:  cntReg <= 4'(RD_GAP_CYC - 1);
        default:   cntReg <= 4'd0;
      endcase
    else if (cntReg != 4'd0) cntReg <= cntReg - 4'd1;
  end

  // Read capture and toggle history; a second toggling read after DQ5 means failure
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdataReg    <= 16'h0000;
      prevReg     <= 16'h0000;
      hasPrevReg  <= 1'b0;
      errCheckReg <= 1'b0;
    end else begin
      if (sampleNow) rdataReg <= dqSync;
      if (accept) begin
        hasPrevReg  <= 1'b0;
        errCheckReg <= 1'b0;
      end else if (stateReg == S_RD_GAP && stateNext == S_RD_WAIT) begin
        prevReg    <= rdataReg;
        hasPrevReg <= 1'b1;
        if (hasPrevReg && rdataReg[DQ_ERROR]) errCheckReg <= 1'b1;
      end
    end
  end

  // Sticky status; a hardware set wins over a software clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      errorReg   <= 1'b0;
      suspReg    <= 1'b0;
      refusedReg <= 1'b0;
      doneReg    <= 1'b0;
    end else begin
      if (opFail) errorReg <= 1'b1;
      else if (opDone && opReg inside {OP_RESET1, OP_RESET3}) errorReg <= 1'b0;
      if (opDone && opReg == OP_SUSPEND) suspReg <= 1'b1;
      else if (opDone && opReg == OP_RESUME) suspReg <= 1'b0;
      if (ctrlWr && !accept) refusedReg <= 1'b1;
      else if (apbWr && paddr == REG_STATUS && pwdata[STAT_REFUSED_BIT]) refusedReg <= 1'b0;
      if (opDone || opFail) doneReg <= 1'b1;
      else if (apbWr && paddr == REG_STATUS && pwdata[STAT_DONE_BIT]) doneReg <= 1'b0;
    end
  end

  a_strobe_excl: assert property (@(posedge clock) disable iff (!rst_n)
    !(!flashPins.weN && !flashPins.oeN)) else $error("write and read strobes overlap");
  a_we_width: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(flashPins.weN) |-> (!flashPins.weN)[*5] ##1 flashPins.weN)
    else $error("write pulse width wrong");
  a_unlock_one: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(flashPins.weN) && stepReg == 3'd0 &&
    opReg inside {OP_RESET3, OP_IDENT, OP_PROGRAM, OP_BYP_ENTER, OP_CHIP_ERASE, OP_BLOCK_ERASE}
    |-> flashPins.addr[10:0] == 11'h555 && flashPins.dqOut[7:0] == 8'hAA)
    else $error("first unlock write wrong");
  a_unlock_two: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(flashPins.weN) && stepReg == 3'd1 && opReg != OP_BYP_PROG && opReg != OP_BYP_EXIT
    |-> flashPins.addr[10:0] == 11'h2AA && flashPins.dqOut[7:0] == 8'h55)
    else $error("second unlock write wrong");
  a_resume_code: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(flashPins.weN) && opReg == OP_RESUME |-> flashPins.dqOut[7:0] == 8'h30)
    else $error("resume code wrong");
  a_suspend_code: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(flashPins.weN) && opReg == OP_SUSPEND |-> flashPins.dqOut[7:0] == 8'hB0)
    else $error("suspend code wrong");
  a_error_lock: assert property (@(posedge clock) disable iff (!rst_n)
    errorReg && ctrlWr && !(opIn inside {OP_RESET1, OP_RESET3}) && stateReg == S_IDLE
    |=> stateReg == S_IDLE && refusedReg) else $error("command passed after error");
  a_program_data: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(flashPins.weN) && opReg == OP_PROGRAM && stepReg == 3'd3
    |-> flashPins.addr == addrReg && flashPins.dqOut == wdataReg)
    else $error("program data write wrong");
  a_poll_stop: assert property (@(posedge clock) disable iff (!rst_n)
    stateReg == S_RD_GAP && cntReg == 4'd0 && opReg != OP_READ && hasPrevReg &&
    prevReg[6] == rdataReg[6] |=> stateReg == S_IDLE && doneReg)
    else $error("settled toggle did not end polling");
  c_program: cover property (@(posedge clock) disable iff (!rst_n)
    opReg == OP_PROGRAM && opDone);
  c_fail: cover property (@(posedge clock) disable iff (!rst_n) opFail);
  c_suspend: cover property (@(posedge clock) disable iff (!rst_n)
    opReg == OP_SUSPEND && opDone);
endmodule : fcsl_flash_ctrl
`default_nettype wire

// ### bench/fcsl_flash_model.sv
// Behavioural flash device answering the controller's pin bundle
`timescale 1ns/1ps
`default_nettype none
module fcsl_flash_model #(
  parameter int          PROG_T  = 20,
  parameter int          WIN_T   = 20,
  parameter int          ERASE_T = 50,
  parameter int          HALT_T  = 10,
  parameter logic [15:0] MAKER   = 16'h0A5C,
  parameter logic [15:0] PART    = 16'h0C3A
) (
  input  wire fcsl_pkg::fcsl_pins_type pins,
  input  wire logic                    failNext,
  output logic [15:0]                  dqIn
);
  import fcsl_pkg::*;
  // Durations are ticks of 100 ns, identity values arbitrary
  logic [15:0] mem [16];
  logic [15:0] rdReg, pv, sel;
  int          step, mode, pLeft, eLeft, win, hCnt;
  logic        pBusy, eBusy, susp, halt, err, tgl, tgl2, tmr;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {pBusy, eBusy, susp, halt, err, tgl, tgl2, tmr} = 8'h00;
    {rdReg, pv, sel} = 48'h0;
    {step, mode} = 64'h0;
  end
  // Cells only lose ones when programmed
  task automatic launch(input logic [15:0] fa, input logic [15:0] fd);
    pBusy = 1'b1;
    pv = fd;
    pLeft = PROG_T;
    mem[fa[15:12]] = mem[fa[15:12]] & fd;
  endtask
  // Command decode, only low address and data bits compared
  task automatic cmd(input logic [15:0] fa, input logic [15:0] fd);
    logic [10:0] a;
    logic [7:0]  d;
    logic        u1, u2;
    a = fa[10:0];
    d = fd[7:0];
    u1 = (a == UNLOCK_ADDR1);
    u2 = (a == UNLOCK_ADDR2);
    if (err) begin
      if (d == CODE_RESET) {err, pBusy, eBusy, step, sel} = 51'h0;
      return;
    end
    if (pBusy) return;
    if (eBusy && !susp) begin
      if (d == CODE_SUSPEND && !tmr) susp = 1'b1;
      else if (d == CODE_SUSPEND) {halt, hCnt} = {1'b1, HALT_T};
      else if (d == CODE_BLOCK && !tmr) {sel[fa[15:12]], win} = {1'b1, WIN_T};
      return;
    end
    if (susp && step == 0 && mode == 0 && d == CODE_RESUME) begin
      {susp, tmr} = 2'b01;
      return;
    end
    if (mode == 2) begin
      case (step)
        0: step = (d == CODE_PROGRAM) ? 1 : (d == CODE_IDENT) ? 2 : 0;
        1: begin launch(fa, fd); step = 0; end
        default: begin mode = (d == CODE_EXIT2) ? 0 : 2; step = 0; end
      endcase
      return;
    end
    // Any mismatch falls back to step zero with mode kept, except a write of F0, which also clears mode
    case (step)
      0: step = (u1 && d == CODE_UNLOCK1) ? 1 : 0;
      1: step = (u2 && d == CODE_UNLOCK2) ? 2 : 0;
      2: begin
        step = 0;
        if (d == CODE_RESET) mode = 0;
        else if (u1 && d == CODE_IDENT) mode = 1;
        else if (u1 && d == CODE_BYPASS) mode = 2;
        else if (u1 && d == CODE_PROGRAM) step = 3;
        else if (u1 && d == CODE_ERASE && !susp) step = 4;
      end
      3: begin launch(fa, fd); step = 0; end
      4: step = (u1 && d == CODE_UNLOCK1) ? 5 : 0;
      5: step = (u2 && d == CODE_UNLOCK2) ? 6 : 0;
      default: begin
        step = 0;
        if (u1 && d == CODE_CHIP) {eBusy, tmr, sel} = {2'b11, 16'hFFFF};
        if (d == CODE_BLOCK) {eBusy, tmr, sel, win} = {2'b10, 16'h1 << fa[15:12], WIN_T};
        eLeft = ERASE_T;
      end
    endcase
    if (step == 0 && d == CODE_RESET) mode = 0;
  endtask
  always @(posedge pins.weN) if (!pins.ceN) cmd(pins.addr, pins.dqOut);
  // Status word whenever busy, or erasing block while suspended
  function automatic logic [15:0] look(input logic [15:0] fa);
    logic s;
    s = sel[fa[15:12]];
    if (pBusy) return {8'h00, ~pv[7], tgl, err, 5'h00};
    if (mode == 1) return fa[0] ? PART : MAKER;
    if (eBusy && (!susp || s))
      return {8'h00, susp, tgl, err, 1'b0, tmr, s & tgl2, 2'b00};
    return mem[fa[15:12]];
  endfunction
  always @(negedge pins.oeN) if (!pins.ceN) begin
    rdReg = look(pins.addr);
    if (pBusy || (eBusy && !susp)) tgl = ~tgl;
    if (eBusy && sel[pins.addr[15:12]]) tgl2 = ~tgl2;
  end
  // Embedded controller time base; a failed program stays busy until reset
  always #100 begin
    if (pBusy && !err && pLeft > 0) begin
      pLeft = pLeft - 1;
      if (pLeft == 0) {err, pBusy} = {2{failNext}};
    end
    if (halt && --hCnt <= 0) {halt, susp} = 2'b01;
    if (eBusy && !susp && !tmr && --win <= 0) tmr = 1'b1;
    else if (eBusy && !susp && tmr && !err && --eLeft <= 0) begin
      // A failed erase keeps its blocks selected so DQ2 still marks them
      if (failNext) err = 1'b1;
      else begin
        for (int i = 0; i < 16; i++) if (sel[i]) mem[i] = 16'hFFFF;
        {eBusy, sel} = 17'h0;
      end
    end
  end
  // Released bus shows the inverse so stale data cannot pass
  assign dqIn = (!pins.oeN && !pins.ceN) ? rdReg : pins.dqOe ? pins.dqOut : ~rdReg;
endmodule : fcsl_flash_model
`default_nettype wire

// ### bench/fcsl_flash_ctrl_tb.sv
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module fcsl_flash_ctrl_tb;
  import fcsl_pkg::*;
  localparam logic [15:0] MAKER_ID = 16'h0A5C; // Arbitrary value
  localparam logic [15:0] PART_ID  = 16'h0C3A; // Arbitrary value
  logic          clock, rst_n, psel, penable, pwrite, pready, pslverr, failNext, lastErr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd, lfsr;
  logic [15:0]   dqIn;
  logic [3:0]    b;
  logic [15:0]   shadow [16];
  fcsl_pins_type flashPins;
  int            num_errors, cmp_count;
  fcsl_flash_ctrl uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .flashPins(flashPins), .dqIn(dqIn));
  fcsl_flash_model #(.MAKER(MAKER_ID), .PART(PART_ID)) flash (.pins(flashPins),
    .failNext(failNext), .dqIn(dqIn));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] nextRnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Program can only clear bits
  function automatic logic [15:0] progExp(input logic [15:0] o, input logic [15:0] n);
    return o & n;
  endfunction
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin num_errors++; give_verdict(); end
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Start an operation and wait for busy to drop; rd ends as STATUS
  task automatic runOp(input logic [3:0] op, input logic [15:0] a, input logic [15:0] d,
                       input logic nw);
    int n;
    apb(REG_ADDR, 1'b1, {16'h0, a});
    apb(REG_WDATA, 1'b1, {16'h0, d});
    apb(REG_CTRL, 1'b1, {27'h0, nw, op});
    n = 0;
    do begin apb(REG_STATUS, 1'b0, 32'h0); n++; end
    while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    if (n >= 3000) begin num_errors++; give_verdict(); end
  endtask
  task automatic chkWord(input logic [15:0] a, input logic [15:0] e);
    runOp(OP_READ, a, 16'h0, 1'b0);
    apb(REG_RDATA, 1'b0, 32'h0);
    chk("flash word", {16'h0, e}, rd);
  endtask
  initial begin
    {psel, penable, pwrite, failNext, rst_n} = 5'h0;
    {paddr, pwdata} = 40'h0;
    {num_errors, cmp_count} = 64'h0;
    lfsr = 32'h3CB3C9FF;
    foreach (shadow[i]) shadow[i] = 16'hFFFF;
    repeat (16) @(posedge clock);
    chk("idle pins", 32'h7, {29'h0, flashPins.ceN, flashPins.oeN, flashPins.weN});
    rst_n <= 1'b1;
    @(posedge clock);
    apb(8'h14, 1'b0, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, lastErr});
    // Random programs, each block twice so ones meet zeros
    for (int i = 0; i < 8; i++) begin
      lfsr = nextRnd(lfsr);
      b = 4'(i % 4 + 1);
      runOp(OP_PROGRAM, {b, lfsr[11:0]}, lfsr[31:16], 1'b0);
      shadow[b] = progExp(shadow[b], lfsr[31:16]);
      chkWord({b, 12'h000}, shadow[b]);
    end
    runOp(OP_IDENT, 16'h0, 16'h0, 1'b0);
    chkWord(16'h0000, MAKER_ID);
    chkWord(16'h0001, PART_ID);
    runOp(OP_RESET3, 16'h0, 16'h0, 1'b0);
    chkWord(16'h1000, shadow[1]);
    runOp(OP_BYP_ENTER, 16'h0, 16'h0, 1'b0);
    lfsr = nextRnd(lfsr);
    runOp(OP_BYP_PROG, 16'h5123, lfsr[15:0], 1'b0);
    shadow[5] = progExp(shadow[5], lfsr[15:0]);
    chkWord(16'h5000, shadow[5]);
    runOp(OP_BYP_EXIT, 16'h0, 16'h0, 1'b0);
    chkWord(16'h5000, shadow[5]);
    // Failed program, then refusal, then reset clears the error
    failNext <= 1'b1;
    runOp(OP_PROGRAM, 16'h6000, 16'h1234, 1'b0);
    chk("error flag", 32'h1, {31'h0, rd[STAT_ERROR_BIT]});
    failNext <= 1'b0;
    runOp(OP_PROGRAM, 16'h6000, 16'h1234, 1'b0);
    chk("refused flag", 32'h1, {31'h0, rd[STAT_REFUSED_BIT]});
    runOp(OP_RESET1, 16'h0, 16'h0, 1'b0);
    chk("error cleared", 32'h0, {31'h0, rd[STAT_ERROR_BIT]});
    // Two-block erase, suspended twice with work on another block
    runOp(OP_BLOCK_ERASE, 16'h1000, 16'h0, 1'b1);
    runOp(OP_BLOCK_ADD, 16'h2000, 16'h0, 1'b1);
    repeat (300) @(posedge clock);
    for (int k = 0; k < 2; k++) begin
      runOp(OP_SUSPEND, 16'h1000, 16'h0, 1'b0);
      chk("suspended", 32'h1, {31'h0, rd[STAT_SUSP_BIT]});
      apb(REG_RDATA, 1'b0, 32'h0);
      chk("suspend status", 32'h88, rd & 32'hFFFFFFA8);
      lfsr = nextRnd(lfsr);
      runOp(OP_PROGRAM, 16'h3000, lfsr[15:0], 1'b0);
      shadow[3] = progExp(shadow[3], lfsr[15:0]);
      chkWord(16'h3000, shadow[3]);
      runOp(OP_RESUME, 16'h1000, 16'h0, ~k[0]);
      repeat (100) @(posedge clock);
    end
    shadow[1] = 16'hFFFF;
    shadow[2] = 16'hFFFF;
    chkWord(16'h1000, shadow[1]);
    chkWord(16'h2000, shadow[2]);
    chkWord(16'h3000, shadow[3]);
    // Failed block erase: last status word shows DQ5 and DQ3 set, DQ7 clear
    failNext <= 1'b1;
    runOp(OP_BLOCK_ERASE, 16'h4000, 16'h0, 1'b0);
    chk("erase error flag", 32'h1, {31'h0, rd[STAT_ERROR_BIT]});
    apb(REG_RDATA, 1'b0, 32'h0);
    chk("erase error status", 32'h28, rd & 32'hFFFFFFA8);
    failNext <= 1'b0;
    runOp(OP_RESET1, 16'h0, 16'h0, 1'b0);
    chk("erase error cleared", 32'h0, {31'h0, rd[STAT_ERROR_BIT]});
    runOp(OP_CHIP_ERASE, 16'h0, 16'h0, 1'b0);
    chkWord(16'h5000, 16'hFFFF);
    give_verdict();
  end
endmodule : fcsl_flash_ctrl_tb
`default_nettype wire
